// ### dv/tb.sv
// Self-checking bench for the transmit descriptor controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import txdc_pkg::*;
  // --------------------
  // Signals and scoreboard
  // --------------------
  localparam int SC = 8;
  logic clk, resetn, desc_valid, desc_ready, poll_demand, tx_suspended;
  logic [31:0] desc_status, desc_ctrl, mem_data, tx_data, wb_status, cc, cw, rnd, rr;
  logic buf_req_valid, buf_req_second, buf_req_ready, mem_valid, mem_last, mem_ready;
  logic [TXDC_LEN_W-1:0] buf_req_len;
  logic tx_valid, tx_last, tx_ready, tx_abort, tx_crc_append, tx_pad_enable, tx_setup_frame;
  logic mac_result_valid, mac_excess_coll, mac_deferred, link_fail, wb_valid, wb_ready;
  logic [TXDC_TALLY_W-1:0] mac_collisions;
  logic [1:0] desc_advance, filter_type;
  logic filter_load, tx_done_event, tx_underflow_event, starve, hold_rdy, crc, pad;
  logic due = 1'b0, drop = 1'b0, sec = 1'b0;
  logic [40:0] en;
  logic [40:0] wq[$];
  logic [32:0] dq[$];
  int num_errors = 0;
  int tests_run = 0;
  int seed = 92;
  txdc_ctrl #(.STARVE_CYC(SC)) txdc_ctrl_i (.clk, .resetn, .desc_valid, .desc_status,
    .desc_ctrl, .desc_ready, .poll_demand, .tx_suspended, .buf_req_valid, .buf_req_second,
    .buf_req_len, .buf_req_ready, .mem_valid, .mem_data, .mem_last, .mem_ready, .tx_valid,
    .tx_data, .tx_last, .tx_ready, .tx_abort, .tx_crc_append, .tx_pad_enable, .tx_setup_frame,
    .mac_result_valid, .mac_collisions, .mac_excess_coll, .mac_deferred, .link_fail,
    .wb_valid, .wb_status, .desc_advance, .wb_ready, .filter_load, .filter_type,
    .tx_done_event, .tx_underflow_event);
  txdc_host_mem txdc_host_mem_i (.clk, .resetn, .starve, .buf_req_valid, .buf_req_len,
    .buf_req_ready, .mem_valid, .mem_data, .mem_last, .mem_ready);
  // --------------------
  // Compare, verdict and drivers
  // --------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Offers one descriptor, notes its write-back, feeds results until written back
  task automatic run_desc(input logic [31:0] c, input logic own, input logic [6:0] r,
    input logic st);
    logic [31:0] s;
    logic fin, ab;
    logic [1:0] adv;
    fin = c[TXDC_CTRL_FINAL];
    @(posedge clk);
    #1;
    cc = c;
    starve = st;
    hold_rdy = st;
    {link_fail, mac_deferred, mac_excess_coll, mac_collisions} = r;
    desc_ctrl = c;
    desc_status = {own, 31'h0};
    desc_valid = 1'b1;
    do @(posedge clk); while (!desc_ready);
    #1;
    desc_valid = 1'b0;
    desc_status = ~desc_status;
    desc_ctrl = ~c;
    if (!own)
      return;
    if (c[TXDC_CTRL_INITIAL])
      {crc, pad} = {!c[23] | !c[26], !c[23]};
    adv = c[25] ? TXDC_ADV_RING : (c[24] ? TXDC_ADV_CHAIN : TXDC_ADV_SEQ);
    s = st ? 32'h0000_8002 : 32'h0;
    if (fin && !c[27] && !st)
      s = {16'h0, r[4] | r[6], 6'h0, r[4], 1'b0, r[4] ? 4'h0 : r[3:0], r[6], 1'b0, r[5]};
    wq.push_back({c[31] && (fin || c[27]) || st, st, c[27], c[28], c[22], crc, pad, adv, s});
    for (int k = 0; k < 400; k++)
    begin
      @(posedge clk);
      if (wb_valid && wb_ready)
        break;
      ab = tx_abort;
      #1;
      if (ab)
        starve = 1'b0;
      mac_result_valid = fin && !c[27] && k[1:0] == 2'h3;
    end
    #1;
    mac_result_valid = 1'b0;
    starve = 1'b0;
    hold_rdy = 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic poll();
    @(posedge clk);
    #1;
    poll_demand = 1'b1;
    @(posedge clk);
    #1;
    poll_demand = 1'b0;
    repeat (3) @(posedge clk);
    chk(tx_suspended, 1'b0);
  endtask
  always #2 clk = ~clk;
  // Random stalls on both sinks; the transmitter sink alone is held open while a starvation is staged
  always @(posedge clk)
  begin
    #1;
    rr = $random(seed);
    tx_ready = hold_rdy | rr[0];
    wb_ready = rr[1] | rr[2];
  end
  // Write-back notes and stream words are checked oldest first
  always @(posedge clk)
  begin
    if (due)
    begin
      chk(tx_done_event, en[40]);
      chk(tx_underflow_event, en[39]);
      chk(filter_load, en[38]);
      if (en[38])
        chk(filter_type, en[37:36]);
    end
    due = 1'b0;
    if (wb_valid && wb_ready)
    begin
      en = wq.pop_front();
      chk(wb_status, en[31:0]);
      chk(desc_advance, en[33:32]);
      chk({tx_crc_append, tx_pad_enable}, en[35:34]);
      chk(tx_setup_frame, en[38]);
      due = 1'b1;
      drop = 1'b0;
    end
    if (tx_abort)
      drop = 1'b1;
    if (tx_abort)
      dq.delete();
    if (buf_req_valid && buf_req_ready)
      sec = buf_req_second;
    if (mem_valid && mem_ready && !drop)
      dq.push_back({mem_last && cc[30] && sec == (cc[21:11] != 0 && (cc[25] || !cc[24])),
        mem_data});
    if (tx_valid && tx_ready && !drop)
      chk({tx_last, tx_data}, dq.pop_front());
  end
  initial
  begin
    {clk, resetn, desc_valid, poll_demand, starve, hold_rdy} = 6'h0;
    {mac_result_valid, link_fail, crc, pad} = 4'h3;
    {desc_status, desc_ctrl, mac_collisions, mac_excess_coll, mac_deferred} = 70'h0;
    repeat (8) @(posedge clk);
    #1;
    resetn = 1'b1;
    run_desc(32'h6000_0008, 1'b0, 7'h0, 1'b0);
    repeat (4) @(posedge clk);
    chk(tx_suspended, 1'b1);
    poll();
    for (int f = 0; f < 4; f++)
      run_desc(32'he800_0008 | {3'h0, f[1], 5'h0, f[0], 22'h0}, 1'b1, 7'h0, 1'b0);
    run_desc(32'ha480_0010, 1'b1, 7'h0, 1'b0);
    run_desc(32'h4000_0008, 1'b1, 7'h25, 1'b0);
    run_desc(32'h6000_6000, 1'b1, 7'h4b, 1'b0);
    for (int i = 0; i < 14; i++)
    begin
      rnd = $random(seed);
      cw = (rnd & 32'h8780_0000) | 32'h6000_0000 | {16'h0, rnd[4:0], 6'h0, rnd[20:16] | 5'h1};
      run_desc(cw, 1'b1, rnd[15:9], 1'b0);
    end
    run_desc(32'he000_2010, 1'b1, 7'h0, 1'b1);
    repeat (4) @(posedge clk);
    chk(tx_suspended, 1'b1);
    poll();
    chk(wq.size(), 0);
    end_of_test();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire

// ### dv/txdc_ctrl_sva.sv
// Port assertions for the transmit descriptor controller
`timescale 1ns/1ps
`default_nettype none
module txdc_ctrl_sva
  import txdc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int STARVE_CYC = TXDC_STARVE_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Requests and stream
  input wire logic buf_req_valid,
  input wire logic buf_req_ready,
  input wire logic buf_req_second,
  input wire logic [TXDC_LEN_W-1:0] buf_req_len,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_abort,
  // Options, write-back and events
  input wire logic tx_crc_append,
  input wire logic tx_pad_enable,
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire logic [31:0] wb_status,
  input wire logic tx_suspended,
  input wire logic filter_load,
  input wire logic tx_done_event,
  input wire logic tx_underflow_event
);
  logic [7:0] starve_ff, nxt_starve;
  // --------------------
  // Starvation run length
  // --------------------
  // Saturates so a long idle spell cannot wrap into a short one
  assign nxt_starve = (tx_valid || !tx_ready) ? 8'h00 : starve_ff + {7'h0, starve_ff != 8'hff};
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      starve_ff <= 8'h00;
    else
      starve_ff <= nxt_starve;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_OWN_BACK: assert property (wb_valid |-> !wb_status[31])
    else $error("write-back keeps device ownership");
  AST_TALLY_VOID: assert property (wb_valid && wb_status[8] |-> wb_status[6:3] == 4'h0)
    else $error("tally kept with excess collisions");
  AST_ERR_SUM: assert property (wb_valid |-> wb_status[15] == (|{wb_status[8], wb_status[2:1]}))
    else $error("error summary wrong");
  AST_WB_HOLD: assert property (wb_valid && !wb_ready |=> wb_valid && $stable(wb_status))
    else $error("write-back changed before taken");
  AST_EV_CAUSE: assert property ((tx_done_event || filter_load) |-> $past(wb_valid && wb_ready))
    else $error("event without write-back");
  AST_UF_CAUSE: assert property (tx_underflow_event |-> tx_done_event && $past(wb_status[1]))
    else $error("underflow event not paired");
  AST_UF_SUSP: assert property (tx_underflow_event |-> ##[0:4] tx_suspended)
    else $error("no suspension after underflow");
  AST_ABORT: assert property (tx_abort |-> starve_ff >= STARVE_CYC - 1)
    else $error("abort without starvation");
  AST_PAD_CRC: assert property (tx_pad_enable |-> tx_crc_append)
    else $error("padding without crc");
  AST_REQ_LEN: assert property (buf_req_valid |-> buf_req_len != 0)
    else $error("zero length requested");
  AST_REQ_HOLD: assert property (buf_req_valid && !buf_req_ready |=>
    buf_req_valid && $stable({buf_req_len, buf_req_second}))
    else $error("request changed before taken");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("stream word lost in stall");
endmodule
bind txdc_ctrl txdc_ctrl_sva #(.DATA_W(DATA_W), .STARVE_CYC(STARVE_CYC)) txdc_ctrl_sva_i (
  .clk, .resetn, .buf_req_valid, .buf_req_ready, .buf_req_second, .buf_req_len, .tx_valid,
  .tx_ready, .tx_data, .tx_abort, .tx_crc_append, .tx_pad_enable, .wb_valid, .wb_ready,
  .wb_status, .tx_suspended, .filter_load, .tx_done_event, .tx_underflow_event);
`default_nettype wire

// ### dv/txdc_host_mem.sv
// Host memory model: grants buffer requests and returns data beats
`timescale 1ns/1ps
`default_nettype none
module txdc_host_mem
  import txdc_pkg::*;
(
  // Clock, reset and starvation control
  input wire logic clk,
  input wire logic resetn,
  input wire logic starve,
  // Buffer requests
  input wire logic buf_req_valid,
  input wire logic [TXDC_LEN_W-1:0] buf_req_len,
  output logic buf_req_ready,
  // Data beats
  output logic mem_valid,
  output logic [31:0] mem_data,
  output logic mem_last,
  input wire logic mem_ready
);
  logic [TXDC_LEN_W-1:0] left_ff, beats_ff, n;
  logic [31:0] seq_ff;
  logic go;
  // --------------------
  // Grant and beat engine
  // --------------------
  // Grant on alternate cycles so requests wait; starving holds back all but the first beat
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      buf_req_ready <= 1'b0;
      left_ff <= '0;
      beats_ff <= '0;
      seq_ff <= 32'h0;
      mem_valid <= 1'b0;
      mem_last <= 1'b0;
      mem_data <= 32'h0;
    end
    else
    begin
      n = left_ff - {10'h0, mem_valid && mem_ready};
      go = n != 0 && (!starve || n == beats_ff);
      buf_req_ready <= buf_req_valid && !buf_req_ready;
      if (buf_req_valid && buf_req_ready)
      begin
        n = (buf_req_len + 11'h3) >> 2;
        beats_ff <= n;
        go = n != 0;
      end
      left_ff <= n;
      // An offered beat stays put until taken; idle data toggles so stale values never match
      if (!mem_valid || mem_ready)
      begin
        mem_valid <= go;
        mem_last <= go && n == 11'h1;
        mem_data <= go ? seq_ff : ~mem_data;
        seq_ff <= seq_ff + {31'h0, go};
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/txdc_ctrl.sv
// Transmit descriptor controller: walks descriptors, moves buffers, writes status
`timescale 1ns/1ps
`default_nettype none
module txdc_ctrl
  import txdc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int STARVE_CYC = TXDC_STARVE_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Descriptor fetch: control word and status word of the current descriptor
  input wire logic desc_valid,
  input wire logic [31:0] desc_status,
  input wire logic [31:0] desc_ctrl,
  output logic desc_ready,
  // Restart after suspension
  input wire logic poll_demand,
  output logic tx_suspended,
  // Buffer read requests to host memory
  output logic buf_req_valid,
  output logic buf_req_second,
  output logic [TXDC_LEN_W-1:0] buf_req_len,
  input wire logic buf_req_ready,
  // Buffer data from host memory
  input wire logic mem_valid,
  input wire logic [DATA_W-1:0] mem_data,
  input wire logic mem_last,
  output logic mem_ready,
  // Frame data to the transmitter or address filter loader
  output logic tx_valid,
  output logic [DATA_W-1:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic tx_abort,
  // Per-frame options
  output logic tx_crc_append,
  output logic tx_pad_enable,
  output logic tx_setup_frame,
  // Transmit result from the transmitter
  input wire logic mac_result_valid,
  input wire logic [TXDC_TALLY_W-1:0] mac_collisions,
  input wire logic mac_excess_coll,
  input wire logic mac_deferred,
  input wire logic link_fail,
  // Status write-back and next-descriptor choice
  output logic wb_valid,
  output logic [31:0] wb_status,
  output logic [1:0] desc_advance,
  input wire logic wb_ready,
  // Address filter selection
  output logic filter_load,
  output logic [1:0] filter_type,
  // Events
  output logic tx_done_event,
  output logic tx_underflow_event
);

  localparam int SCW = $clog2(STARVE_CYC + 1);

  // -------------------------------------------------------------------------
  // State and held fields
  // -------------------------------------------------------------------------
  txdc_state_t state_ff, nxt_state;
  logic [31:0] ctrl_ff;
  logic [31:0] stat_ff;
  logic under_ff;
  logic in_frame_ff;
  logic [SCW-1:0] starve_ff;
  logic desc_ready_ff, buf_req_valid_ff, buf_req_second_ff, wb_valid_ff;
  logic [TXDC_LEN_W-1:0] buf_req_len_ff;
  logic tx_abort_ff, tx_crc_ff, tx_pad_ff, setup_ff;
  logic filter_load_ff, done_ev_ff, under_ev_ff, susp_ff;
  logic [1:0] filter_type_ff, advance_ff;

  // -------------------------------------------------------------------------
  // Control word decode
  // -------------------------------------------------------------------------
  wire is_final = ctrl_ff[TXDC_CTRL_FINAL];
  wire is_setup = ctrl_ff[TXDC_CTRL_SETUP];
  wire ring = ctrl_ff[TXDC_CTRL_RING];
  wire chain = ctrl_ff[TXDC_CTRL_CHAIN];
  wire [TXDC_LEN_W-1:0] len1 = ctrl_ff[TXDC_CTRL_LEN1_MSB:TXDC_CTRL_LEN1_LSB];
  wire [TXDC_LEN_W-1:0] len2 = ctrl_ff[TXDC_CTRL_LEN2_MSB:TXDC_CTRL_LEN2_LSB];
  // Chaining reuses the second address word, so its length means nothing then
  wire use1 = (len1 != '0);
  // Ring wrap overrides chaining, and then the second buffer is a real buffer
  wire use2 = (ring || !chain) && (len2 != '0) && !under_ff;
  // Ring wrap wins whenever both linking bits are set
  wire [1:0] adv_sel = ring ? TXDC_ADV_RING : (chain ? TXDC_ADV_CHAIN : TXDC_ADV_SEQ);
  wire [1:0] ft_sel = {ctrl_ff[TXDC_CTRL_FT_HI], ctrl_ff[TXDC_CTRL_FT_LO]};
  wire take_desc = desc_valid && desc_ready_ff;
  wire owned = desc_status[TXDC_STAT_OWN];
  wire first_seg = desc_ctrl[TXDC_CTRL_INITIAL];
  wire nxt_pad = !desc_ctrl[TXDC_CTRL_PAD_INH];
  // Padding on means a CRC is always added, whatever the inhibit bit says
  wire nxt_crc = nxt_pad || !desc_ctrl[TXDC_CTRL_CRC_INH];
  wire in_data1 = (state_ff == TXDC_S_DATA1);
  wire in_data2 = (state_ff == TXDC_S_DATA2);
  wire moving = in_data1 || in_data2 || (state_ff == TXDC_S_REQ2);
  wire beat = mem_valid && mem_ready && (in_data1 || in_data2);
  wire beat_last = beat && mem_last;
  wire buf_last = in_data2 || !use2;
  wire wb_done = wb_valid_ff && wb_ready;
  wire req_take = buf_req_valid_ff && buf_req_ready;

  // -------------------------------------------------------------------------
  // Data path through the two-entry buffer; dropped while aborting
  // -------------------------------------------------------------------------
  wire fifo_in_valid = beat && !under_ff;
  wire fifo_last = mem_last && is_final && buf_last;
  wire [DATA_W:0] fifo_out;
  wire fifo_out_valid;

  txdc_skid_fifo #(
    .WIDTH(DATA_W + 1),
    .DEPTH(TXDC_BUF_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(fifo_in_valid),
    .in_data({fifo_last, mem_data}),
    .in_ready(mem_ready),
    .out_ready(tx_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out)
  );

  assign tx_valid = fifo_out_valid;
  assign tx_data = fifo_out[DATA_W-1:0];
  assign tx_last = fifo_out[DATA_W];

  // -------------------------------------------------------------------------
  // Starvation watch: transmitter waiting mid-frame with nothing buffered
  // -------------------------------------------------------------------------
  wire starving = in_frame_ff && moving && tx_ready && !fifo_out_valid && !under_ff;
  wire underrun = starving && (starve_ff == SCW'(STARVE_CYC - 1));
  wire tx_beat = tx_valid && tx_ready;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      starve_ff <= '0;
    else
      starve_ff <= starving ? starve_ff + SCW'(1) : '0;
  end

  // Tracks whether a frame has begun leaving towards the transmitter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      in_frame_ff <= 1'b0;
    else if (underrun || (tx_beat && tx_last))
      in_frame_ff <= 1'b0;
    else if (tx_beat)
      in_frame_ff <= 1'b1;
  end

  // -------------------------------------------------------------------------
  // Descriptor walk
  // -------------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      TXDC_S_IDLE:
        if (take_desc)
          nxt_state = owned ? TXDC_S_REQ1 : TXDC_S_SUSP;
      TXDC_S_REQ1:
        if (!use1)
          nxt_state = TXDC_S_REQ2;
        else if (req_take)
          nxt_state = TXDC_S_DATA1;
      TXDC_S_DATA1:
        if (beat_last)
          nxt_state = TXDC_S_REQ2;
      TXDC_S_REQ2:
        if (!use2)
          nxt_state = TXDC_S_END;
        else if (req_take)
          nxt_state = TXDC_S_DATA2;
      TXDC_S_DATA2:
        if (beat_last)
          nxt_state = TXDC_S_END;
      TXDC_S_END:
        if (!under_ff && is_final && !is_setup && !fifo_out_valid)
          nxt_state = TXDC_S_RESULT;
        else if (under_ff || !is_final || is_setup)
          nxt_state = TXDC_S_WB;
      TXDC_S_RESULT:
        if (mac_result_valid)
          nxt_state = TXDC_S_WB;
      TXDC_S_WB:
        if (wb_done)
          nxt_state = under_ff ? TXDC_S_SUSP : TXDC_S_IDLE;
      TXDC_S_SUSP:
        if (poll_demand)
          nxt_state = TXDC_S_IDLE;
      default:
        nxt_state = TXDC_S_IDLE;
    endcase
  end

  // State register and registered handshake outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= TXDC_S_IDLE;
      desc_ready_ff <= 1'b0;
      buf_req_valid_ff <= 1'b0;
      buf_req_second_ff <= 1'b0;
      buf_req_len_ff <= '0;
      wb_valid_ff <= 1'b0;
      susp_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      desc_ready_ff <= (nxt_state == TXDC_S_IDLE) && !take_desc;
      // Held off in the take cycle: the lengths then still show the old word
      buf_req_valid_ff <= ((nxt_state == TXDC_S_REQ1) && (state_ff == TXDC_S_REQ1)
                          && use1 && !req_take)
                          || ((nxt_state == TXDC_S_REQ2) && use2 && !req_take);
      buf_req_second_ff <= (nxt_state == TXDC_S_REQ2);
      buf_req_len_ff <= (nxt_state == TXDC_S_REQ2) ? len2 : len1;
      wb_valid_ff <= (nxt_state == TXDC_S_WB) && !wb_done;
      susp_ff <= (nxt_state == TXDC_S_SUSP);
    end
  end

  // -------------------------------------------------------------------------
  // Descriptor fields and per-frame options
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_ff <= TXDC_CTRL_RST;
      tx_crc_ff <= 1'b1;
      tx_pad_ff <= 1'b1;
      setup_ff <= 1'b0;
    end
    else if (take_desc && owned)
    begin
      ctrl_ff <= desc_ctrl;
      setup_ff <= desc_ctrl[TXDC_CTRL_SETUP];
      // Options only change at a frame start; later segments keep them
      if (first_seg)
      begin
        tx_crc_ff <= nxt_crc;
        tx_pad_ff <= nxt_pad;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Underflow abort; cleared only once the host is told
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      under_ff <= 1'b0;
      tx_abort_ff <= 1'b0;
    end
    else
    begin
      tx_abort_ff <= underrun;
      if (underrun)
        under_ff <= 1'b1;
      else if (wb_done)
        under_ff <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Completion status, written in one word with ownership returned
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      stat_ff <= TXDC_STAT_RST;
    else if (take_desc)
      stat_ff <= TXDC_STAT_RST;
    else if ((state_ff == TXDC_S_RESULT) && mac_result_valid)
    begin
      // A tally beside excess collisions is not meaningful, so it reads zero
      stat_ff[TXDC_STAT_TALLY_MSB:TXDC_STAT_TALLY_LSB] <=
        mac_excess_coll ? '0 : mac_collisions;
      stat_ff[TXDC_STAT_EXCESS] <= mac_excess_coll;
      stat_ff[TXDC_STAT_LINK] <= link_fail;
      stat_ff[TXDC_STAT_CARRIER] <= mac_deferred;
      stat_ff[TXDC_STAT_ERR_SUM] <= mac_excess_coll || link_fail;
    end
    else if ((state_ff == TXDC_S_END) && under_ff)
    begin
      stat_ff[TXDC_STAT_UNDER] <= 1'b1;
      stat_ff[TXDC_STAT_ERR_SUM] <= 1'b1;
    end
  end

  // Own bit stays clear in the written word: status and hand back are atomic
  assign wb_status = {1'b0, stat_ff[30:0]};

  // -------------------------------------------------------------------------
  // Events, filter selection and next-descriptor choice
  // -------------------------------------------------------------------------
  wire done_irq = ctrl_ff[TXDC_CTRL_DONE_IRQ] && (is_final || is_setup);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      done_ev_ff <= 1'b0;
      under_ev_ff <= 1'b0;
      filter_load_ff <= 1'b0;
      filter_type_ff <= TXDC_FT_PERFECT;
      advance_ff <= TXDC_ADV_SEQ;
    end
    else
    begin
      done_ev_ff <= wb_done && (under_ff || done_irq);
      under_ev_ff <= wb_done && under_ff;
      filter_load_ff <= wb_done && is_setup && !under_ff;
      if (wb_done && is_setup)
        filter_type_ff <= ft_sel;
      if ((nxt_state == TXDC_S_WB) && (state_ff != TXDC_S_WB))
        advance_ff <= adv_sel;
    end
  end

  // -------------------------------------------------------------------------
  // Output drive
  // -------------------------------------------------------------------------
  assign desc_ready = desc_ready_ff;
  assign tx_suspended = susp_ff;
  assign buf_req_valid = buf_req_valid_ff;
  assign buf_req_second = buf_req_second_ff;
  assign buf_req_len = buf_req_len_ff;
  assign tx_abort = tx_abort_ff;
  assign tx_crc_append = tx_crc_ff;
  assign tx_pad_enable = tx_pad_ff;
  assign tx_setup_frame = setup_ff;
  assign wb_valid = wb_valid_ff;
  assign desc_advance = advance_ff;
  assign filter_load = filter_load_ff;
  assign filter_type = filter_type_ff;
  assign tx_done_event = done_ev_ff;
  assign tx_underflow_event = under_ev_ff;

endmodule
`default_nettype wire

// ### hw/txdc_pkg.sv
// Constants, field layouts and state types of the transmit descriptor controller
package txdc_pkg;

  // -------------------------------------------------------------------------
  // Control word field positions
  // -------------------------------------------------------------------------
  localparam int TXDC_CTRL_DONE_IRQ = 31;
  localparam int TXDC_CTRL_FINAL = 30;
  localparam int TXDC_CTRL_INITIAL = 29;
  localparam int TXDC_CTRL_FT_HI = 28;
  localparam int TXDC_CTRL_SETUP = 27;
  localparam int TXDC_CTRL_CRC_INH = 26;
  localparam int TXDC_CTRL_RING = 25;
  localparam int TXDC_CTRL_CHAIN = 24;
  localparam int TXDC_CTRL_PAD_INH = 23;
  localparam int TXDC_CTRL_FT_LO = 22;
  localparam int TXDC_CTRL_LEN2_MSB = 21;
  localparam int TXDC_CTRL_LEN2_LSB = 11;
  localparam int TXDC_CTRL_LEN1_MSB = 10;
  localparam int TXDC_CTRL_LEN1_LSB = 0;
  localparam int TXDC_LEN_W = 11;

  // -------------------------------------------------------------------------
  // Status word field positions
  // -------------------------------------------------------------------------
  localparam int TXDC_STAT_OWN = 31;
  localparam int TXDC_STAT_ERR_SUM = 15;
  localparam int TXDC_STAT_EXCESS = 8;
  localparam int TXDC_STAT_TALLY_MSB = 6;
  localparam int TXDC_STAT_TALLY_LSB = 3;
  localparam int TXDC_STAT_LINK = 2;
  localparam int TXDC_STAT_UNDER = 1;
  localparam int TXDC_STAT_CARRIER = 0;
  localparam int TXDC_TALLY_W = 4;

  // -------------------------------------------------------------------------
  // Encodings, reset values and cycle counts
  // -------------------------------------------------------------------------
  localparam logic [1:0] TXDC_ADV_SEQ = 2'h0;
  localparam logic [1:0] TXDC_ADV_RING = 2'h1;
  localparam logic [1:0] TXDC_ADV_CHAIN = 2'h2;
  localparam logic [1:0] TXDC_FT_PERFECT = 2'h0;
  localparam logic [1:0] TXDC_FT_HASH_ONE = 2'h1;
  localparam logic [1:0] TXDC_FT_INVERSE = 2'h2;
  localparam logic [1:0] TXDC_FT_HASH_ONLY = 2'h3;
  localparam logic [31:0] TXDC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TXDC_STAT_RST = 32'h0000_0000;
  localparam int TXDC_STARVE_CYC = 16;
  localparam int TXDC_BUF_DEPTH = 2;

  typedef enum logic [3:0] {
    TXDC_S_IDLE,
    TXDC_S_REQ1,
    TXDC_S_DATA1,
    TXDC_S_REQ2,
    TXDC_S_DATA2,
    TXDC_S_END,
    TXDC_S_RESULT,
    TXDC_S_WB,
    TXDC_S_SUSP
  } txdc_state_t;

endpackage

// ### hw/txdc_skid_fifo.sv
// Small shift-register FIFO between host memory data and the transmitter
`timescale 1ns/1ps
`default_nettype none
module txdc_skid_fifo
  import txdc_pkg::*;
#(
  parameter int WIDTH = 33,
  parameter int DEPTH = TXDC_BUF_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Head always sits in entry 0 so the output is a plain register
  assign out_data = mem_ff[0];
  assign out_valid = (cnt_ff != '0);
  assign in_ready = (cnt_ff != CNT_FULL);
  assign nxt_cnt = cnt_ff + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);

  // -------------------------------------------------------------------------
  // Per-entry storage: shift down on pop, write at the tail on push
  // -------------------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    logic [WIDTH-1:0] above;
    wire fill_here = push && (pop ? (cnt_ff == CW'(i + 1)) : (cnt_ff == CW'(i)));
    if (i == DEPTH - 1)
    begin : g_top
      assign above = mem_ff[i];
    end
    else
    begin : g_mid
      assign above = mem_ff[i + 1];
    end
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        mem_ff[i] <= '0;
      else if (fill_here)
        mem_ff[i] <= in_data;
      else if (pop)
        mem_ff[i] <= above;
    end
  end

  // Occupancy count
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule
`default_nettype wire
